// ==== hdl/isoe_defines.vh ====
// Constants for the three-opcode execute block: map, fields, opcodes, classes.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef ISOE_DEFINES_VH
`define ISOE_DEFINES_VH

// Register byte offsets
`define ISOE_OFF_INSTR 12'h000
`define ISOE_OFF_ACC 12'h004
`define ISOE_OFF_STATUS 12'h008
`define ISOE_FILE_REGION 3'h1
`define ISOE_FILE_COUNT 128

// Status field positions
`define ISOE_ST_ZERO 0
`define ISOE_ST_BUSY 1
`define ISOE_ST_SKIP 2
`define ISOE_ST_UNSUP 3

// Instruction fields
`define ISOE_OPC_INCR_SKIP 6'h0f
`define ISOE_OPC_OR_LIT 6'h38
`define ISOE_OPC_OR_REG 6'h04
`define ISOE_DEST_BIT 7

// Operation classes handed to the datapath
`define ISOE_CLS_NONE 2'h0
`define ISOE_CLS_INCR 2'h1
`define ISOE_CLS_OR 2'h2

// Reset values
`define ISOE_ACC_RST 8'h00
`define ISOE_ZERO_RST 1'b0

// Bus responses
`define ISOE_RESP_OKAY 2'h0
`define ISOE_RESP_SLVERR 2'h2
`define ISOE_RESP_DECERR 2'h3

`endif

// ==== hdl/isoe_alu.v ====
// Datapath of the execute block: increment or inclusive OR, zero detect.
// Assumes the caller latches the results; purely combinational.
`timescale 1ns/1ps
`include "isoe_defines.vh"

module isoe_alu (
	// Operation
	input wire [1:0] op_class,
	input wire [7:0] operand,
	input wire [7:0] acc,
	// Result
	output reg [7:0] result,
	output wire result_zero
);

	always @* begin
		case (op_class)
			`ISOE_CLS_INCR: result = operand + 8'h01;
			`ISOE_CLS_OR: result = operand | acc;
			default: result = 8'h00;
		endcase
	end

	assign result_zero = (result == 8'h00);

endmodule // isoe_alu

// ==== hdl/isoe_exec.v ====
// Top of the execute block: AXI4-Lite slave, four-phase sequencer, file registers.
// Assumes one clock aclk, synchronous active-low reset, aclken freezing all state.
`timescale 1ns/1ps
`include "isoe_defines.vh"

module isoe_exec (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	input wire aclken,
	// Write address
	input wire awvalid,
	output reg awready,
	input wire [11:0] awaddr,
	input wire [2:0] awprot,
	// Write data
	input wire wvalid,
	output reg wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	// Write response
	output reg bvalid,
	input wire bready,
	output reg [1:0] bresp,
	// Read address
	input wire arvalid,
	output reg arready,
	input wire [11:0] araddr,
	input wire [2:0] arprot,
	// Read data
	output reg rvalid,
	input wire rready,
	output reg [31:0] rdata,
	output reg [1:0] rresp
);

	localparam PH_IDLE = 3'd0;
	localparam PH_Q1 = 3'd1;
	localparam PH_Q2 = 3'd2;
	localparam PH_Q3 = 3'd3;
	localparam PH_Q4 = 3'd4;

	reg [7:0] file_mem [0:`ISOE_FILE_COUNT-1];
	reg [2:0] phase_q;
	reg [13:0] instr_q;
	reg nop_cycle_q;
	reg skip_pend_q;
	reg unsup_q;
	reg [7:0] acc_q;
	reg zero_q;
	reg [1:0] cls_q;
	reg dest_q;
	reg upd_zero_q;
	reg [6:0] faddr_q;
	reg [7:0] operand_q;
	reg [7:0] res_q;
	reg res_zero_q;
	reg aw_hold_q;
	reg w_hold_q;
	reg [11:0] waddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;

	wire busy = (phase_q != PH_IDLE);
	wire do_write = aw_hold_q && w_hold_q && !bvalid;
	wire w_file = (waddr_q[11:9] == `ISOE_FILE_REGION);
	wire w_instr = (waddr_q == `ISOE_OFF_INSTR);
	wire w_acc = (waddr_q == `ISOE_OFF_ACC);
	wire w_stat = (waddr_q == `ISOE_OFF_STATUS);
	wire w_mapped = w_file || w_instr || w_acc || w_stat;
	// Refusing every write while busy keeps software off the Q4 write port
	wire w_ok = w_mapped && !busy;
	wire r_file = (araddr[11:9] == `ISOE_FILE_REGION);
	wire [5:0] opc = instr_q[13:8];
	wire [7:0] alu_res;
	wire alu_zero;
	wire [7:0] status_word = {4'h0, unsup_q, skip_pend_q, busy, zero_q};

	isoe_alu u_alu (
		.op_class(cls_q),
		.operand(operand_q),
		.acc(acc_q),
		.result(alu_res),
		.result_zero(alu_zero)
	);

	// Write channels, taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			waddr_q <= 12'h000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `ISOE_RESP_OKAY;
		end else if (aclken) begin
			if (awvalid && awready) begin
				aw_hold_q <= 1'b1;
				awready <= 1'b0;
				waddr_q <= {awaddr[11:2], 2'b00};
			end
			if (wvalid && wready) begin
				w_hold_q <= 1'b1;
				wready <= 1'b0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid <= 1'b1;
				bresp <= !w_mapped ? `ISOE_RESP_DECERR : (busy ? `ISOE_RESP_SLVERR : `ISOE_RESP_OKAY);
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `ISOE_RESP_OKAY;
		end else if (aclken) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rresp <= `ISOE_RESP_OKAY;
				if (r_file) begin
					rdata <= {24'h000000, file_mem[araddr[8:2]]};
				end else if ({araddr[11:2], 2'b00} == `ISOE_OFF_INSTR) begin
					rdata <= {18'h00000, instr_q};
				end else if ({araddr[11:2], 2'b00} == `ISOE_OFF_ACC) begin
					rdata <= {24'h000000, acc_q};
				end else if ({araddr[11:2], 2'b00} == `ISOE_OFF_STATUS) begin
					rdata <= {24'h000000, status_word};
				end else begin
					rdata <= 32'h00000000;
					rresp <= `ISOE_RESP_DECERR;
				end
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// File registers: software port when idle, Q4 write otherwise
	always @(posedge aclk) begin
		if (aclken) begin
			if (do_write && w_ok && w_file && wstrb_q[0]) begin
				file_mem[waddr_q[8:2]] <= wdata_q[7:0];
			end else if (phase_q == PH_Q4 && !nop_cycle_q && cls_q != `ISOE_CLS_NONE && dest_q) begin
				file_mem[faddr_q] <= res_q;
			end
		end
	end

	// Four-phase sequencer and accumulator
	always @(posedge aclk) begin
		if (!aresetn) begin
			phase_q <= PH_IDLE;
			instr_q <= 14'h0000;
			nop_cycle_q <= 1'b0;
			skip_pend_q <= 1'b0;
			unsup_q <= 1'b0;
			acc_q <= `ISOE_ACC_RST;
			zero_q <= `ISOE_ZERO_RST;
			cls_q <= `ISOE_CLS_NONE;
			dest_q <= 1'b0;
			upd_zero_q <= 1'b0;
			faddr_q <= 7'h00;
			operand_q <= 8'h00;
			res_q <= 8'h00;
			res_zero_q <= 1'b0;
		end else if (aclken) begin
			case (phase_q)
				PH_IDLE: begin
					if (do_write && w_ok) begin
						if (w_instr) begin
							instr_q <= wdata_q[13:0];
							// Pending skip consumes this word as nop
							nop_cycle_q <= skip_pend_q;
							skip_pend_q <= 1'b0;
							phase_q <= PH_Q1;
						end
						if (w_acc && wstrb_q[0]) begin
							acc_q <= wdata_q[7:0];
						end
						if (w_stat && wstrb_q[0]) begin
							zero_q <= wdata_q[`ISOE_ST_ZERO];
							if (wdata_q[`ISOE_ST_SKIP]) begin
								skip_pend_q <= 1'b0;
							end
						end
					end
				end
				PH_Q1: begin
					faddr_q <= instr_q[6:0];
					dest_q <= instr_q[`ISOE_DEST_BIT];
					if (nop_cycle_q) begin
						cls_q <= `ISOE_CLS_NONE;
						upd_zero_q <= 1'b0;
					end else if (opc == `ISOE_OPC_INCR_SKIP) begin
						cls_q <= `ISOE_CLS_INCR;
						upd_zero_q <= 1'b0;
					end else if (opc == `ISOE_OPC_OR_LIT) begin
						cls_q <= `ISOE_CLS_OR;
						upd_zero_q <= 1'b1;
						dest_q <= 1'b0;
					end else if (opc == `ISOE_OPC_OR_REG) begin
						cls_q <= `ISOE_CLS_OR;
						upd_zero_q <= 1'b1;
					end else begin
						cls_q <= `ISOE_CLS_NONE;
						upd_zero_q <= 1'b0;
					end
					unsup_q <= !nop_cycle_q && opc != `ISOE_OPC_INCR_SKIP && opc != `ISOE_OPC_OR_LIT
						&& opc != `ISOE_OPC_OR_REG;
					phase_q <= PH_Q2;
				end
				PH_Q2: begin
					operand_q <= (opc == `ISOE_OPC_OR_LIT) ? instr_q[7:0] : file_mem[faddr_q];
					phase_q <= PH_Q3;
				end
				PH_Q3: begin
					res_q <= alu_res;
					res_zero_q <= alu_zero;
					phase_q <= PH_Q4;
				end
				PH_Q4: begin
					if (cls_q != `ISOE_CLS_NONE && !dest_q) begin
						acc_q <= res_q;
					end
					if (upd_zero_q) begin
						// Zero set or cleared by result
						zero_q <= res_zero_q;
					end
					if (cls_q == `ISOE_CLS_INCR && res_zero_q) begin
						skip_pend_q <= 1'b1;
					end
					nop_cycle_q <= 1'b0;
					phase_q <= PH_IDLE;
				end
				default: phase_q <= PH_IDLE;
			endcase
		end
	end

endmodule // isoe_exec

// ==== tb/isoe_exec_props.sv ====
// Bus handshake checker for the execute block.
// Assumes aclken held high; sees only the top's ports.
`timescale 1ns/1ps
module isoe_exec_props (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Bus
	input wire awvalid,
	input wire awready,
	input wire wvalid,
	input wire wready,
	input wire bvalid,
	input wire bready,
	input wire [1:0] bresp,
	input wire arvalid,
	input wire arready,
	input wire rvalid,
	input wire rready,
	input wire [31:0] rdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wtake_s; awvalid && awready && wvalid && wready; endsequence
	sequence wdone_s; bvalid && bready; endsequence
	// Both halves latch on the take edge; the response is set one edge later
	b_follows_a: assert property (wtake_s |=> ##1 bvalid) else $error("write not answered");
	b_holds_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp moved");
	w_blocked_a: assert property (bvalid |-> !awready && !wready) else $error("write open early");
	w_reopen_a: assert property (wdone_s |=> !bvalid && awready && wready) else $error("write not freed");
	r_follows_a: assert property (arvalid && arready |=> rvalid) else $error("read not answered");
	r_holds_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
	r_blocked_a: assert property (rvalid |-> !arready) else $error("read open early");
	r_reopen_a: assert property (rvalid && rready |=> !rvalid && arready) else $error("read not freed");
endmodule // isoe_exec_props
bind isoe_exec isoe_exec_props chk_u (.*);

// ==== tb/isoe_host.sv ====
// Bus master model: one write and one read at a time.
// Assumes the bench's hang task ends a stuck wait.
`timescale 1ns/1ps
module isoe_host (
	// Clock
	input wire aclk,
	// From slave
	input wire awready,
	input wire wready,
	input wire bvalid,
	input wire [1:0] bresp,
	input wire arready,
	input wire rvalid,
	input wire [31:0] rdata,
	input wire [1:0] rresp,
	// To slave
	output reg awvalid = 1'b0,
	output reg [11:0] awaddr = 12'h0,
	output reg [2:0] awprot = 3'h0,
	output reg wvalid = 1'b0,
	output reg [31:0] wdata = 32'h0,
	output reg [3:0] wstrb = 4'h0,
	output reg bready = 1'b0,
	output reg arvalid = 1'b0,
	output reg [11:0] araddr = 12'h0,
	output reg [2:0] arprot = 3'h0,
	output reg rready = 1'b0
);
	// Late mode holds ready off for three edges so the slave must hold its answer
	bit late = 1'b0;
	task wr(input [11:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
		int n;
		begin
			n = 0;
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			wstrb <= s;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= !late;
			do begin
				@(posedge aclk);
				n++;
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
				if (late && n == 3) bready <= 1'b1;
			end while (!(bvalid && bready) && n < 60);
			if (!(bvalid && bready)) incr_skip_and_or_exec_bench.hang();
			r = bresp;
			bready <= 1'b0;
		end
	endtask
	task rd(input [11:0] a, output [31:0] d, output [1:0] r);
		int n;
		begin
			n = 0;
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= !late;
			do begin
				@(posedge aclk);
				n++;
				if (arready) arvalid <= 1'b0;
				if (late && n == 3) rready <= 1'b1;
			end while (!(rvalid && rready) && n < 60);
			if (!(rvalid && rready)) incr_skip_and_or_exec_bench.hang();
			d = rdata;
			r = rresp;
			rready <= 1'b0;
		end
	endtask
endmodule // isoe_host

// ==== tb/incr_skip_and_or_exec_bench.sv ====
// Bench for the execute block: opcodes, destination, skip, timing.
// Assumes isoe_host as bus master; checker bound to the top.
`timescale 1ns/1ps
`include "isoe_defines.vh"
module incr_skip_and_or_exec_bench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic aclken = 1'b1;
	wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	wire [11:0] awaddr, araddr;
	wire [2:0] awprot, arprot;
	wire [31:0] wdata, rdata;
	wire [3:0] wstrb;
	wire [1:0] bresp, rresp;
	logic [31:0] d;
	logic [1:0] r;
	int err_count = 0;
	int checks = 0;
	isoe_exec dut_u (.*);
	isoe_host host_u (.*);
	always #10 aclk = ~aclk;
	task cmp_d(input [31:0] g, input [31:0] e);
		begin
			checks++;
			if (g !== e) begin
				err_count++;
				$display("ERROR %0t got %h want %h", $time, g, e);
			end
		end
	endtask
	task cmp_r(input [1:0] g, input [1:0] e);
		cmp_d({30'h0, g}, {30'h0, e});
	endtask
	task rdc(input [11:0] a, input [31:0] e);
		begin
			host_u.rd(a, d, r);
			cmp_r(r, `ISOE_RESP_OKAY);
			cmp_d(d, e);
		end
	endtask
	task wrc(input [11:0] a, input [31:0] v);
		begin
			host_u.wr(a, v, 4'hf, r);
			cmp_r(r, `ISOE_RESP_OKAY);
		end
	endtask
	// Busy must still show on the first poll and be gone on the second
	task ex(input [13:0] w);
		begin
			wrc(`ISOE_OFF_INSTR, {18'h0, w});
			host_u.rd(`ISOE_OFF_STATUS, d, r);
			cmp_d(32'(d[`ISOE_ST_BUSY]), 32'h1);
			host_u.rd(`ISOE_OFF_STATUS, d, r);
			cmp_d(32'(d[`ISOE_ST_BUSY]), 32'h0);
		end
	endtask
	task t_incr;
		begin
			wrc(`ISOE_OFF_STATUS, 32'h1);
			wrc(12'h214, 32'h41);
			ex(14'h0f85);
			rdc(12'h214, 32'h42);
			rdc(`ISOE_OFF_STATUS, 32'h1);
			ex(14'h0f05);
			rdc(`ISOE_OFF_ACC, 32'h43);
			rdc(12'h214, 32'h42);
			$display("incr test ends");
		end
	endtask
	task t_skip;
		begin
			wrc(`ISOE_OFF_ACC, 32'h10);
			wrc(12'h218, 32'hff);
			ex(14'h0f86);
			rdc(12'h218, 32'h0);
			rdc(`ISOE_OFF_STATUS, 32'h5);
			ex(14'h3801);
			rdc(`ISOE_OFF_ACC, 32'h10);
			ex(14'h3801);
			rdc(`ISOE_OFF_ACC, 32'h11);
			$display("skip test ends");
		end
	endtask
	task t_orlit;
		begin
			wrc(`ISOE_OFF_ACC, 32'h9a);
			ex(14'h3835);
			rdc(`ISOE_OFF_ACC, 32'hbf);
			rdc(`ISOE_OFF_STATUS, 32'h0);
			wrc(`ISOE_OFF_ACC, 32'h0);
			ex(14'h3800);
			rdc(`ISOE_OFF_STATUS, 32'h1);
			$display("or literal test ends");
		end
	endtask
	task t_orreg;
		begin
			wrc(`ISOE_OFF_ACC, 32'h91);
			wrc(12'h21c, 32'h13);
			ex(14'h0407);
			rdc(`ISOE_OFF_ACC, 32'h93);
			rdc(12'h21c, 32'h13);
			rdc(`ISOE_OFF_STATUS, 32'h0);
			wrc(`ISOE_OFF_ACC, 32'h0);
			wrc(12'h21c, 32'h0);
			ex(14'h0487);
			rdc(12'h21c, 32'h0);
			rdc(`ISOE_OFF_STATUS, 32'h1);
			$display("or register test ends");
		end
	endtask
	task t_bus;
		begin
			host_u.late = 1'b1;
			host_u.rd(12'h100, d, r);
			cmp_r(r, `ISOE_RESP_DECERR);
			cmp_d(d, 32'h0);
			host_u.wr(12'h100, 32'h5, 4'hf, r);
			cmp_r(r, `ISOE_RESP_DECERR);
			host_u.wr(`ISOE_OFF_ACC, 32'h77, 4'h0, r);
			cmp_r(r, `ISOE_RESP_OKAY);
			rdc(`ISOE_OFF_ACC, 32'h0);
			host_u.late = 1'b0;
			$display("bus test ends");
		end
	endtask
	// Back-to-back write lands in Q4 and must be refused
	task t_refuse;
		begin
			wrc(`ISOE_OFF_ACC, 32'h21);
			wrc(`ISOE_OFF_INSTR, 32'h2000);
			host_u.wr(`ISOE_OFF_ACC, 32'h5, 4'hf, r);
			cmp_r(r, `ISOE_RESP_SLVERR);
			rdc(`ISOE_OFF_STATUS, 32'h9);
			rdc(`ISOE_OFF_ACC, 32'h21);
			rdc(`ISOE_OFF_INSTR, 32'h2000);
			wrc(12'h220, 32'hff);
			ex(14'h0f88);
			rdc(12'h220, 32'h0);
			rdc(`ISOE_OFF_STATUS, 32'h5);
			wrc(`ISOE_OFF_STATUS, 32'h4);
			rdc(`ISOE_OFF_STATUS, 32'h0);
			ex(14'h3802);
			rdc(`ISOE_OFF_ACC, 32'h23);
			$display("refuse and cancel test ends");
		end
	endtask
	task t_reset;
		begin
			wrc(`ISOE_OFF_STATUS, 32'h1);
			@(posedge aclk);
			aresetn <= 1'b0;
			repeat (3) @(posedge aclk);
			aresetn <= 1'b1;
			rdc(`ISOE_OFF_ACC, 32'h0);
			rdc(`ISOE_OFF_STATUS, 32'h0);
			$display("reset test ends");
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", checks, err_count);
			if (err_count == 0 && checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task hang;
		begin
			err_count++;
			$display("ERROR %0t wait timed out", $time);
			complete_run;
		end
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_incr;
		t_skip;
		t_orlit;
		t_orreg;
		t_bus;
		t_refuse;
		t_reset;
		complete_run;
	end
endmodule // incr_skip_and_or_exec_bench
